// ===== core/flash_bus_regs.svh
`ifndef FLASH_BUS_REGS_SVH
`define FLASH_BUS_REGS_SVH

// array geometry in words
`define FB_PARAM_WORDS 21'h001000
`define FB_PARAM_COUNT 21'h000008
`define FB_LOCK_PARAMS 21'h000002
`define FB_MAIN_WORDS 21'h008000
`define FB_MAIN_COUNT_8M 21'h00000f
`define FB_MAIN_COUNT_16M 21'h00001f
`define FB_ADDR_LINES_8M 5'h13
`define FB_ADDR_LINES_16M 5'h14

// status byte bit positions
`define FB_SR_LOCKED_FAIL 1
`define FB_SR_PROGRAM_FAIL 4
`define FB_SR_ERASE_FAIL 5

// configuration word bit positions
`define FB_CFG_BURST 0
`define FB_CFG_FALLING 1
`define FB_CFG_CONTINUOUS 2

`endif

// ===== core/flash_bus_pkg.sv
package flash_bus_pkg;

  typedef enum logic [0:0] {
    MODE_PAGE,
    MODE_BURST
  } read_mode_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic adv_n;
    logic bclk;
    logic wp_n;
    logic reset_n;
    logic [19:0] addr;
    logic [15:0] data;
  } pins_t;

  typedef struct packed {
    logic falling;
    logic continuous;
  } cfg_t;

  typedef struct packed {
    logic locked_fail;
    logic program_fail;
    logic erase_fail;
  } fail_t;

  typedef struct packed {
    pins_t s1;
    pins_t s2;
    pins_t s3;
    read_mode_t mode;
    cfg_t cfg;
    fail_t fail;
    logic captured;
    logic [19:0] addr;
    logic [15:0] dout;
    logic dout_oe_n;
    logic wait_n;
    logic wait_oe_n;
    logic wr_strobe;
    logic [19:0] wr_addr;
    logic [15:0] wr_data;
    logic prog_go;
    logic erase_go;
    logic [7:0] status;
    logic standby;
    logic auto_reset;
  } state_t;

endpackage : flash_bus_pkg

// ===== core/flash_host_bus_interface.sv
// Behaviour
// - address is captured when the address-valid strobe rises, reads and writes.
// - burst mode captures on first active clock edge or valid rise, whichever first.
// - burst clock is ignored in page mode and during writes.
// - address and data are latched on the write-enable rising edge.
// - data bus floats when chip deselected or output enable inactive.
// - status reads use the low eight data lines only.
// - chip enable high deselects the device into standby.
// - reset pin low blocks writes and resets program/erase automation.
// - reset release resumes asynchronous array reads.
// - read data driven only while output enable asserted in a read.
// - write-protect low locks all main blocks and two parameter blocks.
// - locked program/erase sets locked-fail plus program-fail or erase-fail.
// - write-protect high allows program and erase on lockable blocks.
// - wait signals data-valid only in continuous burst mode.
// - wait driven only with chip and output enable active, else released.
// - 19 address lines at 8 Mbit, 20 at 16 Mbit, held per cycle.
// - eight parameter blocks of 4096 words each, separately erasable.
// - main blocks of 32768 words, fifteen at 8 Mbit, thirty-one at 16.
// - parameter blocks sit at top or bottom of the map per variant.
// - reset clears the status register and returns to array read.
// - burst reads enabled only after the configuration register is written.
`timescale 1ns/1ns
`include "flash_bus_regs.svh"

module flash_host_bus_interface #(
  parameter bit DENSITY_16M = 1'b1,
  parameter bit TOP_BOOT = 1'b1
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  // pins from the host
  input wire logic [19:0] i_word_address,
  input wire logic [15:0] i_data_bus,
  output logic [15:0] o_data_bus,
  output logic o_data_bus_oe_n,
  input wire logic i_chip_en_n,
  input wire logic i_out_en_n,
  input wire logic i_write_en_n,
  input wire logic i_addr_valid_n,
  input wire logic i_burst_clk,
  input wire logic i_write_protect_n,
  input wire logic i_reset_pin_n,
  output logic o_wait_n,
  output logic o_wait_oe_n,
  // core side, same clock
  input wire logic [15:0] i_array_data,
  input wire logic i_status_read,
  input wire logic [7:0] i_core_status,
  input wire logic i_data_valid,
  input wire logic i_cfg_write,
  input wire logic [2:0] i_cfg_data,
  input wire logic i_prog_req,
  input wire logic i_erase_req,
  input wire logic [19:0] i_op_addr,
  input wire logic i_status_clear,
  output logic [19:0] o_read_addr,
  output logic o_burst_mode,
  output logic o_wr_strobe,
  output logic [19:0] o_wr_addr,
  output logic [15:0] o_wr_data,
  output logic o_prog_go,
  output logic o_erase_go,
  output logic [7:0] o_status,
  output logic o_standby,
  output logic o_automation_reset
);

  localparam logic [20:0] MAIN_COUNT =
    DENSITY_16M ? `FB_MAIN_COUNT_16M : `FB_MAIN_COUNT_8M;
  localparam logic [20:0] SPAN =
    21'(MAIN_COUNT * `FB_MAIN_WORDS + `FB_PARAM_COUNT * `FB_PARAM_WORDS);
  localparam logic [20:0] PARAM_SPAN = 21'(`FB_PARAM_COUNT * `FB_PARAM_WORDS);
  localparam logic [20:0] LOCK_SPAN = 21'(`FB_LOCK_PARAMS * `FB_PARAM_WORDS);
  localparam logic [4:0] ADDR_LINES =
    DENSITY_16M ? `FB_ADDR_LINES_16M : `FB_ADDR_LINES_8M;

  flash_bus_pkg::state_t r;
  flash_bus_pkg::state_t nxt;

  // unused upper line reads as zero in the smaller density
  function automatic logic [19:0] mask_addr(input logic [19:0] a);
    logic [19:0] m;
    m = 20'hfffff >> (5'h14 - ADDR_LINES);
    return a & m;
  endfunction : mask_addr

  // lockable: every main block plus the two outermost parameter blocks
  function automatic logic is_lockable(input logic [19:0] a);
    logic [20:0] w;
    logic hit;
    w = {1'b0, mask_addr(a)};
    if (TOP_BOOT) begin
      if (w >= SPAN - PARAM_SPAN) begin
        hit = (w >= SPAN - LOCK_SPAN);
      end else begin
        hit = 1'b1;
      end
    end else begin
      if (w < PARAM_SPAN) begin
        hit = (w < LOCK_SPAN);
      end else begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : is_lockable

  flash_bus_pkg::pins_t pins_in;
  assign pins_in.ce_n = i_chip_en_n;
  assign pins_in.oe_n = i_out_en_n;
  assign pins_in.we_n = i_write_en_n;
  assign pins_in.adv_n = i_addr_valid_n;
  assign pins_in.bclk = i_burst_clk;
  assign pins_in.wp_n = i_write_protect_n;
  assign pins_in.reset_n = i_reset_pin_n;
  assign pins_in.addr = i_word_address;
  assign pins_in.data = i_data_bus;

  always_comb begin
    logic selected;
    logic pin_reset;
    logic adv_rise;
    logic adv_fall;
    logic we_rise;
    logic clk_rise;
    logic clk_fall;
    logic clk_act;
    logic write_ok;
    logic locked;
    logic [7:0] sts;
    selected = 1'b0;
    pin_reset = 1'b0;
    adv_rise = 1'b0;
    adv_fall = 1'b0;
    we_rise = 1'b0;
    clk_rise = 1'b0;
    clk_fall = 1'b0;
    clk_act = 1'b0;
    write_ok = 1'b0;
    locked = 1'b0;
    sts = 8'h00;
    nxt = r;
    // first stage feeds only the second
    nxt.s1 = pins_in;
    nxt.s2 = r.s1;
    nxt.s3 = r.s2;

    pin_reset = ~r.s2.reset_n;
    selected = ~r.s2.ce_n & ~pin_reset;
    adv_rise = r.s2.adv_n & ~r.s3.adv_n;
    adv_fall = ~r.s2.adv_n & r.s3.adv_n;
    we_rise = r.s2.we_n & ~r.s3.we_n;
    clk_rise = r.s2.bclk & ~r.s3.bclk;
    clk_fall = ~r.s2.bclk & r.s3.bclk;
    clk_act = r.cfg.falling ? clk_fall : clk_rise;
    // clock only counts in burst mode outside writes
    if (r.mode != flash_bus_pkg::MODE_BURST || ~r.s2.we_n || ~selected) begin
      clk_act = 1'b0;
    end

    // write cycle: chip and write enable both low, reset pin high
    write_ok = we_rise & ~r.s3.ce_n & ~pin_reset;

    nxt.standby = ~selected;
    nxt.auto_reset = pin_reset;

    // address capture
    if (adv_fall) begin
      nxt.captured = 1'b0;
    end
    if (selected) begin
      if (r.mode == flash_bus_pkg::MODE_BURST) begin
        if (~r.s2.adv_n && clk_act && !r.captured) begin
          nxt.addr = mask_addr(r.s2.addr);
          nxt.captured = 1'b1;
        end else if (adv_rise && !r.captured) begin
          nxt.addr = mask_addr(r.s2.addr);
          nxt.captured = 1'b1;
        end else if (clk_act && r.captured) begin
          // internal burst counter advances on later active edges
          nxt.addr = mask_addr(r.addr + 20'h00001);
        end
      end else begin
        // transparent while valid is held low, frozen on its rise
        if (~r.s2.adv_n || adv_rise) begin
          nxt.addr = mask_addr(r.s2.addr);
        end
      end
    end

    // write latch
    nxt.wr_strobe = 1'b0;
    if (write_ok) begin
      nxt.wr_strobe = 1'b1;
      nxt.wr_addr = mask_addr(r.s2.addr);
      nxt.wr_data = r.s2.data;
      nxt.addr = mask_addr(r.s2.addr);
    end

    // read configuration
    if (i_cfg_write && !pin_reset) begin
      nxt.mode = i_cfg_data[`FB_CFG_BURST] ? flash_bus_pkg::MODE_BURST
                                           : flash_bus_pkg::MODE_PAGE;
      nxt.cfg.falling = i_cfg_data[`FB_CFG_FALLING];
      nxt.cfg.continuous = i_cfg_data[`FB_CFG_CONTINUOUS];
    end

    // program and erase gating by write protect
    locked = ~r.s2.wp_n & is_lockable(i_op_addr);
    nxt.prog_go = i_prog_req & ~locked & ~pin_reset;
    nxt.erase_go = i_erase_req & ~i_prog_req & ~locked & ~pin_reset;

    // sticky fail flags; a set in the clear cycle wins
    if (i_status_clear) begin
      nxt.fail = '0;
    end
    if (locked && i_prog_req && !pin_reset) begin
      nxt.fail.locked_fail = 1'b1;
      nxt.fail.program_fail = 1'b1;
    end else if (locked && i_erase_req && !pin_reset) begin
      nxt.fail.locked_fail = 1'b1;
      nxt.fail.erase_fail = 1'b1;
    end

    // reset pin: array read, page mode, status cleared
    if (pin_reset) begin
      nxt.fail = '0;
      nxt.mode = flash_bus_pkg::MODE_PAGE;
      nxt.cfg = '0;
      nxt.captured = 1'b0;
    end

    sts = i_core_status;
    sts[`FB_SR_LOCKED_FAIL] = r.fail.locked_fail;
    sts[`FB_SR_PROGRAM_FAIL] = r.fail.program_fail;
    sts[`FB_SR_ERASE_FAIL] = r.fail.erase_fail;
    if (pin_reset) begin
      sts = 8'h00;
    end
    nxt.status = sts;

    // data bus drive
    if (selected && ~r.s2.oe_n && r.s2.we_n) begin
      nxt.dout_oe_n = 1'b0;
      if (i_status_read) begin
        nxt.dout = {8'h00, sts};
      end else begin
        nxt.dout = i_array_data;
      end
    end else begin
      nxt.dout_oe_n = 1'b1;
      nxt.dout = 16'h0000;
    end

    // wait line: driven only under chip and output enable
    if (selected && ~r.s2.oe_n) begin
      nxt.wait_oe_n = 1'b0;
      if (r.mode == flash_bus_pkg::MODE_BURST && r.cfg.continuous) begin
        nxt.wait_n = i_data_valid;
      end else begin
        nxt.wait_n = 1'b1;
      end
    end else begin
      nxt.wait_oe_n = 1'b1;
      nxt.wait_n = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
      r.s1.ce_n <= 1'b1;
      r.s1.oe_n <= 1'b1;
      r.s1.we_n <= 1'b1;
      r.s1.adv_n <= 1'b1;
      // idle level, so no false reset-pin pulse follows the release
      r.s1.reset_n <= 1'b1;
      r.s2.ce_n <= 1'b1;
      r.s2.oe_n <= 1'b1;
      r.s2.we_n <= 1'b1;
      r.s2.adv_n <= 1'b1;
      r.s2.reset_n <= 1'b1;
      r.s3.ce_n <= 1'b1;
      r.s3.oe_n <= 1'b1;
      r.s3.we_n <= 1'b1;
      r.s3.adv_n <= 1'b1;
      r.s3.reset_n <= 1'b1;
      r.dout_oe_n <= 1'b1;
      r.wait_n <= 1'b1;
      r.wait_oe_n <= 1'b1;
      r.standby <= 1'b1;
    end else begin
      r <= nxt;
    end
  end

  assign o_data_bus = r.dout;
  assign o_data_bus_oe_n = r.dout_oe_n;
  assign o_wait_n = r.wait_n;
  assign o_wait_oe_n = r.wait_oe_n;
  assign o_read_addr = r.addr;
  assign o_burst_mode = (r.mode == flash_bus_pkg::MODE_BURST);
  assign o_wr_strobe = r.wr_strobe;
  assign o_wr_addr = r.wr_addr;
  assign o_wr_data = r.wr_data;
  assign o_prog_go = r.prog_go;
  assign o_erase_go = r.erase_go;
  assign o_status = r.status;
  assign o_standby = r.standby;
  assign o_automation_reset = r.auto_reset;

endmodule : flash_host_bus_interface

// ===== verif/host_bus_checker.sv
`timescale 1ns/1ns
module host_bus_checker (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [19:0] i_word_address,
  input wire logic [15:0] i_data_bus,
  input wire logic i_chip_en_n,
  input wire logic i_out_en_n,
  input wire logic i_write_en_n,
  input wire logic i_reset_pin_n,
  input wire logic i_status_read,
  input wire logic i_prog_req,
  input wire logic [15:0] o_data_bus,
  input wire logic o_data_bus_oe_n,
  input wire logic o_wait_n,
  input wire logic o_wait_oe_n,
  input wire logic o_burst_mode,
  input wire logic o_wr_strobe,
  input wire logic [19:0] o_wr_addr,
  input wire logic [15:0] o_wr_data,
  input wire logic o_prog_go,
  input wire logic o_automation_reset
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // pins reach the output registers three edges after they are sampled
  data_gate_a: assert property (
    !o_data_bus_oe_n |-> !$past(i_chip_en_n, 3) && !$past(i_out_en_n, 3))
    else $error("data bus driven while disabled");
  write_cause_a: assert property (
    o_wr_strobe |-> $past(i_write_en_n, 3) && !$past(i_write_en_n, 4)
      && !$past(i_chip_en_n, 4) && $past(i_reset_pin_n, 3))
    else $error("write strobe without a write edge");
  write_latch_a: assert property (
    o_wr_strobe |-> o_wr_addr == $past(i_word_address, 3) && o_wr_data == $past(i_data_bus, 3))
    else $error("written word differs from pins");
  strobe_once_a: assert property (o_wr_strobe |=> !o_wr_strobe)
    else $error("write strobe too long");
  prog_cause_a: assert property (o_prog_go |-> $past(i_prog_req))
    else $error("program start without request");
  wait_gate_a: assert property (
    !o_wait_oe_n |-> !$past(i_chip_en_n, 3) && !$past(i_out_en_n, 3))
    else $error("wait driven while disabled");
  wait_mode_a: assert property (!o_burst_mode && !$past(o_burst_mode) |-> o_wait_n)
    else $error("wait low outside burst");
  status_byte_a: assert property (
    $past(i_status_read) && !o_data_bus_oe_n |-> o_data_bus[15:8] == 8'h00)
    else $error("status read uses upper lines");
  pin_reset_a: assert property (
    !$past(i_reset_pin_n, 3) |-> o_automation_reset && !o_burst_mode && !o_wr_strobe)
    else $error("reset pin not obeyed");
  cover property (o_wr_strobe);
  cover property (o_prog_go);
  cover property (!o_wait_oe_n && !o_wait_n);
endmodule : host_bus_checker

// ===== verif/host_model.sv
`timescale 1ns/1ns
module host_model (
  input wire logic i_clock,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic o_adv_n,
  output logic o_bclk,
  output logic [19:0] o_addr,
  output logic [15:0] o_data
);
  initial begin
    o_ce_n = 1'h1;
    o_oe_n = 1'h1;
    o_we_n = 1'h1;
    o_adv_n = 1'h1;
    o_bclk = 1'h0;
    o_addr = 20'h00000;
    o_data = 16'h0000;
  end
  // levels are held four cycles so the device's two-flop sync always sees them
  task automatic frame(input logic [19:0] a, input logic wr, input logic ce,
                       input logic [15:0] d);
    @(posedge i_clock);
    o_ce_n <= ce;
    o_oe_n <= wr;
    o_we_n <= !wr;
    o_adv_n <= 1'h0;
    o_addr <= a;
    o_data <= wr ? d : ~o_data;
    repeat (4) @(posedge i_clock);
    o_adv_n <= 1'h1;
    repeat (4) @(posedge i_clock);
    o_we_n <= 1'h1;
    repeat (4) @(posedge i_clock);
  endtask : frame
  // burst clock runs only inside a frame, 400 ns per phase
  task automatic clocks(input int n);
    @(posedge i_clock);
    repeat (n) begin
      o_bclk <= 1'h1;
      repeat (4) @(posedge i_clock);
      o_bclk <= 1'h0;
      repeat (4) @(posedge i_clock);
    end
  endtask : clocks
  task automatic burst(input logic [19:0] a, input int n);
    @(posedge i_clock);
    o_ce_n <= 1'h0;
    o_oe_n <= 1'h0;
    o_adv_n <= 1'h0;
    o_addr <= a;
    repeat (4) @(posedge i_clock);
    clocks(n);
  endtask : burst
  // a released data line shows the inverse of its last value
  task automatic idle;
    @(posedge i_clock);
    o_ce_n <= 1'h1;
    o_oe_n <= 1'h1;
    o_we_n <= 1'h1;
    o_adv_n <= 1'h1;
    o_data <= ~o_data;
    repeat (4) @(posedge i_clock);
  endtask : idle
endmodule : host_model

// ===== verif/flash_host_bus_interface_bench.sv
`timescale 1ns/1ns
module flash_host_bus_interface_bench;
  typedef struct packed {
    logic prog;
    logic wp_n;
    logic [19:0] addr;
    logic go;
    logic [7:0] st;
  } row_t;
  // top boot, 16 Mbit: only f8000..fdfff stays open with protection on
  row_t rows [8] = '{
    '{1'h1, 1'h0, 20'h00000, 1'h0, 8'h12}, '{1'h0, 1'h0, 20'hff000, 1'h0, 8'h22},
    '{1'h0, 1'h0, 20'hf7fff, 1'h0, 8'h22}, '{1'h1, 1'h0, 20'hfe000, 1'h0, 8'h12},
    '{1'h1, 1'h0, 20'hfdfff, 1'h1, 8'h00}, '{1'h0, 1'h0, 20'hf8000, 1'h1, 8'h00},
    '{1'h1, 1'h1, 20'h00000, 1'h1, 8'h00}, '{1'h0, 1'h1, 20'hff000, 1'h1, 8'h00}};
  logic i_clock = 1'h0;
  logic i_rst_n = 1'h0;
  logic i_chip_en_n, i_out_en_n, i_write_en_n, i_addr_valid_n, i_burst_clk;
  logic i_write_protect_n = 1'h1;
  logic i_reset_pin_n = 1'h1;
  logic i_status_read = 1'h0;
  logic i_data_valid = 1'h1;
  logic i_cfg_write = 1'h0;
  logic i_prog_req = 1'h0;
  logic i_erase_req = 1'h0;
  logic i_status_clear = 1'h0;
  logic [2:0] i_cfg_data = 3'h0;
  logic [7:0] i_core_status = 8'h00;
  logic [19:0] i_op_addr = 20'h00000;
  logic [19:0] i_word_address, o_read_addr, o_wr_addr;
  logic [15:0] i_data_bus, o_data_bus, i_array_data, host_data, o_wr_data;
  logic [7:0] o_status;
  logic o_data_bus_oe_n, o_wait_n, o_wait_oe_n, o_burst_mode, o_wr_strobe, o_prog_go;
  logic o_erase_go, o_standby, o_automation_reset, wait_line;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int strobes = 0;
  assign i_data_bus = !o_data_bus_oe_n ? o_data_bus : host_data;
  assign wait_line = !o_wait_oe_n ? o_wait_n : 1'h1;
  assign i_array_data = ~o_read_addr[15:0];
  flash_host_bus_interface dut_u (.*);
  host_model host_u (
    .i_clock(i_clock),
    .o_ce_n(i_chip_en_n),
    .o_oe_n(i_out_en_n),
    .o_we_n(i_write_en_n),
    .o_adv_n(i_addr_valid_n),
    .o_bclk(i_burst_clk),
    .o_addr(i_word_address),
    .o_data(host_data)
  );
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic close_out;
    if (errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic run_op(input row_t r);
    @(posedge i_clock);
    i_write_protect_n <= r.wp_n;
    i_op_addr <= r.addr;
    repeat (4) @(posedge i_clock);
    i_prog_req <= r.prog;
    i_erase_req <= !r.prog;
    @(posedge i_clock);
    i_prog_req <= 1'h0;
    i_erase_req <= 1'h0;
    @(negedge i_clock);
    chk("start", 20'(r.go), 20'(o_prog_go | o_erase_go));
    // the status byte is registered from the flags one cycle after they set
    @(negedge i_clock);
    chk("status", 20'(r.st), 20'(o_status));
  endtask : run_op
  initial begin
    forever #50 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles++;
    if (o_wr_strobe === 1'h1)
      strobes++;
    if (cycles == 4000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    repeat (6) @(posedge i_clock);
    i_rst_n <= 1'h1;
    foreach (rows[i]) begin
      run_op(rows[i]);
      @(posedge i_clock);
      i_status_clear <= 1'h1;
      @(posedge i_clock);
      i_status_clear <= 1'h0;
    end
    host_u.frame(20'h12345, 1'h1, 1'h0, 16'ha5c3);
    host_u.idle();
    chk("strobes", 20'h1, 20'(strobes));
    chk("wr_addr", 20'h12345, o_wr_addr);
    chk("wr_data", 20'h0a5c3, 20'(o_wr_data));
    host_u.frame(20'h00111, 1'h1, 1'h1, 16'h0f0f);
    host_u.idle();
    chk("deselected write", 20'h1, 20'(strobes));
    i_core_status <= 8'h80;
    host_u.frame(20'h0abcd, 1'h0, 1'h0, 16'h0000);
    chk("read addr", 20'h0abcd, o_read_addr);
    chk("read data", 20'h05432, 20'(i_data_bus));
    host_u.clocks(2);
    chk("page clock", 20'h0abcd, o_read_addr);
    i_status_read <= 1'h1;
    repeat (4) @(posedge i_clock);
    chk("status word", 20'h00080, 20'(i_data_bus));
    chk("page wait", 20'h1, 20'(wait_line));
    i_status_read <= 1'h0;
    i_core_status <= 8'h00;
    host_u.idle();
    chk("released", 20'h1, 20'(o_data_bus_oe_n));
    chk("standby", 20'h1, 20'(o_standby));
    chk("wait released", 20'h1, 20'(o_wait_oe_n));
    i_cfg_write <= 1'h1;
    i_cfg_data <= 3'h5;
    @(posedge i_clock);
    i_cfg_write <= 1'h0;
    i_data_valid <= 1'h0;
    @(negedge i_clock);
    chk("burst mode", 20'h1, 20'(o_burst_mode));
    host_u.burst(20'h00200, 2);
    chk("burst addr", 20'h00201, o_read_addr);
    chk("burst wait", 20'h0, 20'(wait_line));
    i_data_valid <= 1'h1;
    host_u.idle();
    run_op(rows[0]);
    @(posedge i_clock);
    i_reset_pin_n <= 1'h0;
    host_u.frame(20'h00777, 1'h1, 1'h0, 16'h1111);
    host_u.idle();
    chk("reset write", 20'h1, 20'(strobes));
    chk("automation", 20'h1, 20'(o_automation_reset));
    chk("reset status", 20'h0, 20'(o_status));
    chk("reset mode", 20'h0, 20'(o_burst_mode));
    i_reset_pin_n <= 1'h1;
    repeat (4) @(posedge i_clock);
    chk("resumed", 20'h0, 20'(o_automation_reset));
    chk("page after reset", 20'h0, 20'(o_burst_mode));
    host_u.burst(20'h00345, 1);
    chk("held valid", 20'h00345, o_read_addr);
    host_u.idle();
    i_cfg_write <= 1'h1;
    i_cfg_data <= 3'h3;
    i_data_valid <= 1'h0;
    @(posedge i_clock);
    i_cfg_write <= 1'h0;
    host_u.burst(20'h00300, 2);
    chk("falling addr", 20'h00301, o_read_addr);
    chk("fixed wait", 20'h1, 20'(wait_line));
    host_u.idle();
    close_out();
  end
endmodule : flash_host_bus_interface_bench
bind flash_host_bus_interface host_bus_checker chk_u (.*);
